// *** clear_trigger_detect.sv ***
// rising-edge or level detection of the clear position deviation input
`timescale 1ns/1ps
`default_nettype none

module clear_trigger_detect (
    input  wire logic ref_clk,     // system clock
    input  wire logic rst,         // async reset, active high
    input  wire logic level_mode,  // 1: act on level, 0: rising edge
    input  wire logic allowed,     // function permitted by control mode
    input  wire logic pin_in,      // clear position deviation input
    output logic      fire         // one clear request this cycle
);
    logic prev_r;

    // ----------------------------------------------------------------
    // input history
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= pin_in;
        end
    end

    // ----------------------------------------------------------------
    // trigger decision
    // ----------------------------------------------------------------
    always_comb begin
        if (!allowed) begin
            fire = 1'b0;
        end else if (level_mode) begin
            fire = pin_in;
        end else begin
            fire = pin_in & ~prev_r;
        end
    end

endmodule

`default_nettype wire

// *** servo_monitor_config_params.sv ***
// configuration bank for clear-deviation trigger and special function mask
`timescale 1ns/1ps
`default_nettype none

module servo_monitor_config_params
    import servo_monitor_pkg::*;
#(
    parameter int DEV_W   = 32,   // position deviation width
    parameter int MISS_W  = 32,   // missed pulse counter width
    parameter int FREQ_W  = 16,   // frequency parameter width
    parameter int FOUT_W  = 24    // scaled frequency width
) (
    input  wire logic                    ref_clk,                  // system clock
    input  wire logic                    rst,                      // async reset, active high
    // parameter access port
    input  wire logic [15:0]             param_addr,               // parameter address
    input  wire logic                    param_wr,                 // write strobe
    input  wire logic [15:0]             param_wdata,              // write data
    input  wire logic                    param_rd,                 // read strobe
    output logic      [15:0]             param_rdata,              // read data
    output logic                         param_rvalid,             // read data valid
    output logic                         param_err,                // unmapped address
    // clear position deviation
    input  wire logic [15:0]             control_mode_selection,   // active control mode code
    input  wire logic                    clear_position_deviation_input, // clear input
    input  wire logic signed [DEV_W-1:0] deviation_delta,          // per-cycle deviation change
    output logic signed [DEV_W-1:0]      position_deviation,       // accumulated deviation
    // raw monitor detections
    input  wire logic                    alarm_detect,             // bit 2 alarm source
    input  wire logic                    target_rejected_detect,   // target position rejected
    input  wire logic                    ref_pulse_detect,         // reference pulse fault
    input  wire logic                    pulse_signal_detect,      // pulse signal fault
    input  wire logic                    overload_detect,          // motor overload
    input  wire logic                    motor_phase_detect,       // motor phase fault
    input  wire logic                    mains_phase_detect,       // mains phase fault
    input  wire logic                    enc_sim_detect,           // encoder simulation fault
    // gated monitor errors
    output logic                         alarm_err,                // bit 2 alarm
    output logic                         target_rejected_err,      // target position rejected error
    output logic                         ref_pulse_err,            // reference pulse error
    output logic                         pulse_signal_err,         // pulse signal error
    output logic                         overload_err,             // motor overload error
    output logic                         motor_phase_err,          // motor phase error
    output logic                         mains_phase_err,          // mains phase error
    output logic                         enc_sim_err,              // encoder simulation error
    // torque limitation and phase injection
    output logic                         torque_current_limit_en,  // apply torque-mode limit
    output logic                         phase_injection_check_en, // run phase connection check
    // limit switches and pulse input
    input  wire logic                    negative_limit_switch,    // negative limit reached
    input  wire logic                    positive_limit_switch,    // positive limit reached
    input  wire logic [3:0]              limit_handling_setting,   // limit handling code
    input  wire logic                    master_pulse,             // incoming master pulse
    input  wire logic                    fault_reset,              // fault reset request
    output logic                         pulse_inhibit,            // pulse input blocked
    output logic                         pulse_pass,               // master pulse forwarded
    output logic [MISS_W-1:0]            missed_pulses,            // pulses held back at limit
    // frequency scaling
    input  wire logic [FREQ_W-1:0]       frequency_parameter,      // raw frequency value
    output logic [FOUT_W-1:0]            frequency_centihz         // frequency in 0.01 Hz
);
    import servo_monitor_pkg::*;

    logic [15:0]              clear_deviation_trigger_mode_r;
    logic [15:0]              special_function_mask_one_r;
    logic                     clear_fire;
    logic                     limit_hit;
    logic                     limit_latched_r;
    logic                     inhibit_now;
    logic                     discard_setting;
    logic [FOUT_W-1:0]        freq_nxt;

    // ----------------------------------------------------------------
    // parameter registers
    // ----------------------------------------------------------------
    // reserved bits stored as written
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            clear_deviation_trigger_mode_r <= RST_CLEAR_TRIGGER_MODE;
            special_function_mask_one_r    <= RST_SPECIAL_MASK_ONE;
        end else if (param_wr) begin
            if (param_addr == ADDR_CLEAR_TRIGGER_MODE) begin
                clear_deviation_trigger_mode_r <= param_wdata;
            end else if (param_addr == ADDR_SPECIAL_MASK_ONE) begin
                special_function_mask_one_r <= param_wdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // read back
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            param_rdata  <= 16'h0000;
            param_rvalid <= 1'b0;
            param_err    <= 1'b0;
        end else begin
            param_rvalid <= param_rd;
            param_err    <= 1'b0;
            if (!param_rd) begin
                param_rdata <= 16'h0000;
            end else if (param_addr == ADDR_CLEAR_TRIGGER_MODE) begin
                param_rdata <= clear_deviation_trigger_mode_r;
            end else if (param_addr == ADDR_SPECIAL_MASK_ONE) begin
                param_rdata <= special_function_mask_one_r;
            end else begin
                param_rdata <= 16'h0000;
                param_err   <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // clear position deviation
    // ----------------------------------------------------------------
    // only bit 0 of the mode decides
    clear_trigger_detect u_clear_trigger_detect (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .level_mode (clear_deviation_trigger_mode_r[0]),
        .allowed    (control_mode_selection == LINEAR_CONTROL_MODE),
        .pin_in     (clear_position_deviation_input),
        .fire       (clear_fire)
    );

    // clear beats the accumulation of the same cycle
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            position_deviation <= '0;
        end else if (clear_fire) begin
            position_deviation <= '0;
        end else begin
            position_deviation <= position_deviation + deviation_delta;
        end
    end

    // ----------------------------------------------------------------
    // monitor gating
    // ----------------------------------------------------------------
    // errors lag detectors one cycle
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            alarm_err           <= 1'b0;
            target_rejected_err <= 1'b0;
            ref_pulse_err       <= 1'b0;
            pulse_signal_err    <= 1'b0;
            overload_err        <= 1'b0;
            motor_phase_err     <= 1'b0;
            mains_phase_err     <= 1'b0;
            enc_sim_err         <= 1'b0;
        end else begin
            alarm_err           <= alarm_detect & ~special_function_mask_one_r[BIT_ALARM_BLOCK];
            target_rejected_err <= target_rejected_detect
                                   & ~special_function_mask_one_r[BIT_TARGET_REJ_OFF];
            ref_pulse_err       <= ref_pulse_detect & ~special_function_mask_one_r[BIT_REF_PULSE_OFF];
            pulse_signal_err    <= pulse_signal_detect & ~special_function_mask_one_r[BIT_PULSE_SIG_OFF];
            overload_err        <= overload_detect & ~special_function_mask_one_r[BIT_OVERLOAD_OFF];
            motor_phase_err     <= motor_phase_detect & special_function_mask_one_r[BIT_PHASE_MON_ON];
            mains_phase_err     <= mains_phase_detect & ~special_function_mask_one_r[BIT_MAINS_OFF];
            enc_sim_err         <= enc_sim_detect & ~special_function_mask_one_r[BIT_ENC_SIM_OFF];
        end
    end

    // ----------------------------------------------------------------
    // torque limit and phase injection enables
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            torque_current_limit_en  <= 1'b0;
            phase_injection_check_en <= 1'b0;
        end else begin
            torque_current_limit_en  <= ~special_function_mask_one_r[BIT_TORQUE_LIMIT_OFF];
            phase_injection_check_en <= ~special_function_mask_one_r[BIT_INJECT_CHECK_OFF];
        end
    end

    // ----------------------------------------------------------------
    // limit switch pulse inhibit
    // ----------------------------------------------------------------
    assign limit_hit       = negative_limit_switch | positive_limit_switch;
    assign inhibit_now     = limit_hit & ~special_function_mask_one_r[BIT_LIMIT_INHIBIT_OFF];
    assign discard_setting = (limit_handling_setting == LIMIT_SETTING_A)
                           | (limit_handling_setting == LIMIT_SETTING_B);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pulse_inhibit <= 1'b0;
            pulse_pass    <= 1'b0;
        end else begin
            pulse_inhibit <= inhibit_now;
            pulse_pass    <= master_pulse & ~inhibit_now;
        end
    end

    // a new hit wins over the clear
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            limit_latched_r <= 1'b0;
        end else if (limit_hit) begin
            limit_latched_r <= 1'b1;
        end else if (fault_reset) begin
            limit_latched_r <= 1'b0;
        end
    end

    // other settings keep pulses for the motion core
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            missed_pulses <= '0;
        end else if (fault_reset && discard_setting && limit_latched_r) begin
            missed_pulses <= '0;
        end else if (master_pulse && inhibit_now) begin
            missed_pulses <= missed_pulses + MISS_W'(1);
        end
    end

    // ----------------------------------------------------------------
    // frequency unit
    // ----------------------------------------------------------------
    always_comb begin
        if (special_function_mask_one_r[BIT_FREQ_CENTI]) begin
            freq_nxt = FOUT_W'(frequency_parameter);
        end else begin
            freq_nxt = FOUT_W'(frequency_parameter * HZ_TO_CENTIHZ);
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            frequency_centihz <= '0;
        end else begin
            frequency_centihz <= freq_nxt;
        end
    end

    // bits 0, 1, 3 and 10 feed no logic

endmodule

`default_nettype wire

// *** servo_monitor_config_params_sva.sv ***
// concurrent checks for the servo monitor configuration bank
`timescale 1ns/1ps
`default_nettype none

module servo_monitor_config_params_sva
    import servo_monitor_pkg::*;
#(
    parameter int DEV_W  = 32, // deviation width
    parameter int FREQ_W = 16, // raw frequency width
    parameter int FOUT_W = 24  // scaled frequency width
) (
    input wire logic                    ref_clk,                        // clock
    input wire logic                    rst,                            // async reset
    input wire logic [15:0]             param_addr,                     // address
    input wire logic                    param_wr,                       // write strobe
    input wire logic [15:0]             param_wdata,                    // write data
    input wire logic                    param_rd,                       // read strobe
    input wire logic [15:0]             param_rdata,                    // read data
    input wire logic                    param_rvalid,                   // read valid
    input wire logic                    param_err,                      // unmapped read
    input wire logic [15:0]             control_mode_selection,         // control mode
    input wire logic                    clear_position_deviation_input, // clear input
    input wire logic signed [DEV_W-1:0] deviation_delta,                // deviation step
    input wire logic signed [DEV_W-1:0] position_deviation,             // accumulator
    input wire logic                    alarm_detect,                   // raw alarm
    input wire logic                    alarm_err,                      // gated alarm
    input wire logic                    target_rejected_detect,         // raw rejection
    input wire logic                    target_rejected_err,            // gated rejection
    input wire logic                    motor_phase_detect,             // raw phase fault
    input wire logic                    motor_phase_err,                // gated phase fault
    input wire logic                    torque_current_limit_en,        // torque limit on
    input wire logic                    phase_injection_check_en,       // injection check on
    input wire logic                    negative_limit_switch,          // negative limit
    input wire logic                    positive_limit_switch,          // positive limit
    input wire logic                    pulse_inhibit,                  // pulses blocked
    input wire logic [FREQ_W-1:0]       frequency_parameter,            // raw frequency
    input wire logic [FOUT_W-1:0]       frequency_centihz               // scaled frequency
);
    import servo_monitor_pkg::*;

    // ----------------------------------------------------------------
    // shadow of the stored parameters
    // ----------------------------------------------------------------
    logic [15:0] mask_s, mode_s;
    logic        in_d, live, fire_c, mapped;

    assign mapped = (param_addr == ADDR_CLEAR_TRIGGER_MODE) || (param_addr == ADDR_SPECIAL_MASK_ONE);
    assign fire_c = (control_mode_selection == LINEAR_CONTROL_MODE) && clear_position_deviation_input
                    && (mode_s[0] || !in_d);

    // live masks the first edge
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mask_s <= RST_SPECIAL_MASK_ONE;
            mode_s <= RST_CLEAR_TRIGGER_MODE;
            in_d   <= 1'b0;
            live   <= 1'b0;
        end else begin
            if (param_wr && param_addr == ADDR_SPECIAL_MASK_ONE) mask_s <= param_wdata;
            if (param_wr && param_addr == ADDR_CLEAR_TRIGGER_MODE) mode_s <= param_wdata;
            in_d <= clear_position_deviation_input;
            live <= 1'b1;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    chk_read_valid: assert property (param_rd |=> param_rvalid)
        else $error("no rvalid");
    chk_read_refused: assert property (param_rd && !mapped |=> param_err && param_rdata == 16'h0000)
        else $error("no err");
    chk_mask_readback: assert property (param_rd && param_addr == ADDR_SPECIAL_MASK_ONE |=> param_rdata == $past(mask_s))
        else $error("mask rdata");
    chk_clear_fires: assert property (live && fire_c |=> position_deviation == 0)
        else $error("no clear");
    chk_no_clear: assert property (live && !fire_c |=> position_deviation == $past(position_deviation)
        + $past(deviation_delta))
        else $error("bad accumulate");
    chk_alarm_gate: assert property (live |-> alarm_err == ($past(alarm_detect) && !$past(mask_s[2])))
        else $error("alarm gate");
    chk_target_gate: assert property (live |-> target_rejected_err == ($past(target_rejected_detect)
        && !$past(mask_s[4])))
        else $error("target gate");
    chk_phase_enable: assert property (live |-> motor_phase_err == ($past(motor_phase_detect) && $past(mask_s[9])))
        else $error("phase gate");
    chk_torque_limit: assert property (live |-> torque_current_limit_en == !$past(mask_s[5]))
        else $error("torque enable");
    chk_inject_check: assert property (live |-> phase_injection_check_en == !$past(mask_s[15]))
        else $error("inject enable");
    chk_freq_unit: assert property (live |-> frequency_centihz == ($past(mask_s[14]) ? FOUT_W'($past(frequency_parameter))
        : FOUT_W'($past(frequency_parameter)) * FOUT_W'(HZ_TO_CENTIHZ)))
        else $error("freq scale");
    chk_inhibit_set: assert property ((negative_limit_switch || positive_limit_switch) && !mask_s[11] |=> pulse_inhibit)
        else $error("no inhibit");
    chk_inhibit_off: assert property (live && $past(mask_s[11]) |-> !pulse_inhibit)
        else $error("inhibit while off");
endmodule

`default_nettype wire

// *** servo_monitor_config_params_tb.sv ***
// self-checking bench for the servo monitor configuration bank
`timescale 1ns/1ps
`default_nettype none

module servo_monitor_config_params_tb;
    import servo_monitor_pkg::*;
    localparam int DEV_W  = 32;
    localparam int MISS_W = 16;
    localparam int FREQ_W = 16;
    localparam int FOUT_W = 24;

    logic                    ref_clk = 1'b0;
    logic                    rst = 1'b1;
    logic [15:0]             param_addr = 16'h0000, param_wdata = 16'h0000, param_rdata;
    logic                    param_wr = 1'b0, param_rd = 1'b0, param_rvalid, param_err;
    logic [15:0]             control_mode_selection = 16'h4001;
    logic                    clear_position_deviation_input = 1'b0;
    logic signed [DEV_W-1:0] deviation_delta = 32'h0000_0003, position_deviation;
    logic alarm_detect = 1'b0, target_rejected_detect = 1'b0, ref_pulse_detect = 1'b0, pulse_signal_detect = 1'b0;
    logic overload_detect = 1'b0, motor_phase_detect = 1'b0, mains_phase_detect = 1'b0, enc_sim_detect = 1'b0;
    logic alarm_err, target_rejected_err, ref_pulse_err, pulse_signal_err;
    logic overload_err, motor_phase_err, mains_phase_err, enc_sim_err;
    logic torque_current_limit_en, phase_injection_check_en, pulse_inhibit, pulse_pass;
    logic negative_limit_switch = 1'b0, positive_limit_switch = 1'b0, master_pulse = 1'b1, fault_reset = 1'b0;
    logic [3:0]              limit_handling_setting = 4'h0;
    logic [MISS_W-1:0]       missed_pulses;
    logic [FREQ_W-1:0]       frequency_parameter = 16'h0000;
    logic [FOUT_W-1:0]       frequency_centihz;
    int                      err_total = 0;
    int                      num_checks = 0;
    int                      seed = 5;
    logic [16:0]             exp_q[$];

    always #5 ref_clk = ~ref_clk;

    servo_monitor_config_params #(.DEV_W(DEV_W), .MISS_W(MISS_W), .FREQ_W(FREQ_W), .FOUT_W(FOUT_W)) u_dut (.*);

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic fail(input string msg);
        err_total++;
        $display("[FAIL] %0t %s", $time, msg);
    endtask

    task automatic check_rd(input logic [16:0] got, input logic [16:0] exp);
        num_checks++;
        if (got !== exp) fail($sformatf("read got %h expected %h", got, exp));
    endtask

    task automatic check_out(input logic [31:0] got, input logic [31:0] exp, input string msg);
        num_checks++;
        if (got !== exp) fail($sformatf("%s got %h expected %h", msg, got, exp));
    endtask

    // idle edge after each access
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        param_addr  <= a;
        param_wdata <= d;
        param_wr    <= 1'b1;
        @(posedge ref_clk);
        param_wr <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic rd(input logic [15:0] a, input logic [16:0] exp);
        exp_q.push_back(exp);
        param_addr <= a;
        param_rd   <= 1'b1;
        @(posedge ref_clk);
        param_rd <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    always @(negedge ref_clk) begin
        if (param_rvalid === 1'b1) begin
            if (exp_q.size() == 0) fail("stray read");
            else check_rd({param_err, param_rdata}, exp_q.pop_front());
        end
    end

    // far beyond the run
    initial begin
        #100000;
        fail("timeout");
        summarize();
    end

    initial begin
        logic [15:0]       m;
        logic [7:0]        det;
        logic [FREQ_W-1:0] f;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        rd(ADDR_CLEAR_TRIGGER_MODE, {1'b0, RST_CLEAR_TRIGGER_MODE});
        rd(ADDR_SPECIAL_MASK_ONE, {1'b0, RST_SPECIAL_MASK_ONE});
        wr(16'h0366, 16'h1234);
        rd(16'h0366, {1'b1, 16'h0000});
        $display("test registers done");
        for (int i = 0; i < 8; i++) begin
            m   = 16'($random(seed)) & 16'hFFFC;
            det = 8'($random(seed));
            f   = 16'($random(seed));
            {enc_sim_detect, mains_phase_detect, motor_phase_detect, overload_detect,
             pulse_signal_detect, ref_pulse_detect, target_rejected_detect, alarm_detect} <= det;
            frequency_parameter <= f;
            wr(ADDR_SPECIAL_MASK_ONE, m);
            rd(ADDR_SPECIAL_MASK_ONE, {1'b0, m});
            @(negedge ref_clk);
            check_out({enc_sim_err, mains_phase_err, motor_phase_err, overload_err, pulse_signal_err, ref_pulse_err,
                       target_rejected_err, alarm_err},
                      det & {~m[13], ~m[12], m[9], ~m[8], ~m[7], ~m[6], ~m[4], ~m[2]}, "errors");
            check_out({torque_current_limit_en, phase_injection_check_en}, {~m[5], ~m[15]}, "enables");
            check_out(frequency_centihz, m[14] ? FOUT_W'(f) : FOUT_W'(f) * FOUT_W'(HZ_TO_CENTIHZ), "freq");
            @(posedge ref_clk);
        end
        $display("test monitors done");
        wr(ADDR_CLEAR_TRIGGER_MODE, TRIG_LEVEL);
        clear_position_deviation_input <= 1'b1;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        check_out(position_deviation, 32'h0000_0000, "level clear");
        @(posedge ref_clk);
        control_mode_selection <= 16'h4000;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        check_out(position_deviation, 32'h0000_0009, "other mode");
        @(posedge ref_clk);
        control_mode_selection          <= LINEAR_CONTROL_MODE;
        clear_position_deviation_input <= 1'b0;
        wr(ADDR_CLEAR_TRIGGER_MODE, TRIG_RISING_EDGE);
        clear_position_deviation_input <= 1'b1;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        check_out(position_deviation, 32'h0000_0006, "edge clear");
        @(posedge ref_clk);
        $display("test clear done");
        wr(ADDR_SPECIAL_MASK_ONE, RST_SPECIAL_MASK_ONE);
        for (int s = 0; s < 4; s++) begin
            limit_handling_setting <= 4'(s);
            {negative_limit_switch, positive_limit_switch} <= s[0] ? 2'b10 : 2'b01;
            repeat (4) @(posedge ref_clk);
            @(negedge ref_clk);
            check_out({pulse_inhibit, pulse_pass}, 2'b10, "inhibit at limit");
            check_out(missed_pulses != 0, 1'b1, "missed count");
            @(posedge ref_clk);
            {negative_limit_switch, positive_limit_switch} <= 2'b00;
            @(posedge ref_clk);
            fault_reset <= 1'b1;
            @(posedge ref_clk);
            fault_reset <= 1'b0;
            repeat (2) @(posedge ref_clk);
            @(negedge ref_clk);
            check_out(missed_pulses == 0, s == 1 || s == 3, "missed reset");
            @(posedge ref_clk);
        end
        wr(ADDR_SPECIAL_MASK_ONE, 16'h0A00);
        positive_limit_switch <= 1'b1;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        check_out({pulse_inhibit, pulse_pass}, 2'b01, "inhibit off");
        @(posedge ref_clk);
        positive_limit_switch <= 1'b0;
        $display("test limits done");
        repeat (3) @(posedge ref_clk);
        if (exp_q.size() != 0) fail("reads left");
        summarize();
    end
endmodule

bind servo_monitor_config_params servo_monitor_config_params_sva #(.DEV_W(DEV_W), .FREQ_W(FREQ_W), .FOUT_W(FOUT_W)) u_chk (.*);

`default_nettype wire

// *** servo_monitor_pkg.sv ***
// constants shared by the servo monitor configuration bank
package servo_monitor_pkg;

    // ----------------------------------------------------------------
    // register addresses (fieldbus parameter addresses)
    // ----------------------------------------------------------------
    localparam logic [15:0] ADDR_CLEAR_TRIGGER_MODE = 16'h0364;
    localparam logic [15:0] ADDR_SPECIAL_MASK_ONE   = 16'h0382;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] RST_CLEAR_TRIGGER_MODE = 16'h0000;
    localparam logic [15:0] RST_SPECIAL_MASK_ONE   = 16'h0200;

    // ----------------------------------------------------------------
    // trigger mode encodings
    // ----------------------------------------------------------------
    localparam logic [15:0] TRIG_RISING_EDGE = 16'h0000;
    localparam logic [15:0] TRIG_LEVEL       = 16'h0001;

    // ----------------------------------------------------------------
    // special function mask bit positions
    // ----------------------------------------------------------------
    localparam int BIT_RSVD0            = 0;
    localparam int BIT_RSVD1            = 1;
    localparam int BIT_ALARM_BLOCK      = 2;
    localparam int BIT_RSVD3            = 3;
    localparam int BIT_TARGET_REJ_OFF   = 4;
    localparam int BIT_TORQUE_LIMIT_OFF = 5;
    localparam int BIT_REF_PULSE_OFF    = 6;
    localparam int BIT_PULSE_SIG_OFF    = 7;
    localparam int BIT_OVERLOAD_OFF     = 8;
    localparam int BIT_PHASE_MON_ON     = 9;
    localparam int BIT_RSVD10           = 10;
    localparam int BIT_LIMIT_INHIBIT_OFF = 11;
    localparam int BIT_MAINS_OFF        = 12;
    localparam int BIT_ENC_SIM_OFF      = 13;
    localparam int BIT_FREQ_CENTI       = 14;
    localparam int BIT_INJECT_CHECK_OFF = 15;

    // ----------------------------------------------------------------
    // mode codes and scaling
    // ----------------------------------------------------------------
    localparam logic [15:0] LINEAR_CONTROL_MODE = 16'h4001;
    localparam logic [3:0]  LIMIT_SETTING_A     = 4'h1;
    localparam logic [3:0]  LIMIT_SETTING_B     = 4'h3;
    localparam logic [7:0]  HZ_TO_CENTIHZ       = 8'h64;

endpackage
